// ===== design/line_ctrl_pkg.sv
// Purpose: Shared constants and types for the line interface state control block.
// Assumes: One 200 MHz clock, synchronous active-low reset, AXI4-Lite register access.
// Notes: Three-level state pins are carried as two-bit level codes.
package line_ctrl_pkg;

   // Clock rate, kept for derived timing figures
   localparam int unsigned CLK_PERIOD_PS = 5000;

   // Register bus geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   // Register byte addresses
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;

   // Control register fields and reset value
   localparam int unsigned CTRL_LIMIT_LOW_BIT = 0;
   localparam int unsigned CTRL_FORCE_SHUTDOWN_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // Status register field positions
   localparam int unsigned STATUS_STATE_LSB = 0;
   localparam int unsigned STATUS_OFF_HOOK_BIT = 4;
   localparam int unsigned STATUS_GROUND_KEY_BIT = 5;
   localparam int unsigned STATUS_SELECTED_BIT = 6;
   localparam int unsigned STATUS_REQ_LSB = 8;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Feed current limits in mA, per state
   localparam logic [6:0] LIMIT_IDLE_MA = 7'h0C;
   localparam logic [6:0] LIMIT_TALK_HIGH_MA = 7'h3E;
   localparam logic [6:0] LIMIT_TALK_LOW_MA = 7'h2A;
   localparam logic [6:0] LIMIT_NONE_MA = 7'h00;

   // Three-level pin code: zero, positive or negative supply
   typedef enum logic [1:0] {
      LEVEL_ZERO = 2'h0,
      LEVEL_POS = 2'h1,
      LEVEL_NEG = 2'h2
   } level_e;

   // Operating state of the line driver, one-hot
   typedef enum logic [3:0] {
      IDLE_FEED_STATE = 4'h1,
      TALK_STATE = 4'h2,
      RINGING_STATE = 4'h4,
      LINE_SHUTDOWN_STATE = 4'h8
   } line_state_e;

   // AXI4-Lite master to slave signals
   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } axi_req_s;

   // AXI4-Lite slave to master signals
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } axi_resp_s;

endpackage

// ===== design/line_interface_state_control.sv
// Purpose: Control section of a subscriber line kit: select-gated request port,
//          three-level state code, shutdown output and hook/ground-key reporting.
// Assumes: All pins synchronous to clk_i; sense inputs already synchronised.
// Notes: Software reaches a control and a status word over AXI4-Lite.
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// - Power-on request is taken only while select is low.
// - Alert-enable request is taken only while select is low.
// - Ground-key output is driven only while select is low.
// - Hook output is driven only while select is low.
// - Two state pins each carry positive, zero or negative level.
// - Stand-by +5/+5, conversation 0/+5, ringing 0/-5 as (second, first).
// - The six unused pin combinations are never produced.
// - Power-down shows on a separate shutdown output, not on the pair.
// - Both latched requests low selects stand-by.
// - Stand-by keeps sensing and reporting; power-down does no line work.
// - Stand-by limits line current to 12 mA with direct polarity.
// - Request pair decodes to stand-by, conversation, power-down or ringing.
// - Requests latch at select rising edge; state holds until next select. Here the force-shutdown control bit also forces power-down on any edge.
// - With select high the status outputs are released (high impedance).
// - Hook output is low when off hook, high when on hook.
module line_interface_state_control
   import line_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Register bus
   input wire axi_req_s axi_i,
   output axi_resp_s axi_o,
   // Controller request port
   input wire logic select_n_i,
   input wire logic power_on_request_i,
   input wire logic alert_enable_i,
   // Line sense indications from the analog front end
   input wire logic off_hook_sense_i,
   input wire logic ground_key_sense_i,
   // Controller status pins, a level and an output enable each
   output logic hook_state_out_o,
   output logic hook_state_out_oe_o,
   output logic ground_key_out_o,
   output logic ground_key_out_oe_o,
   // Line driver control
   output level_e state_level_a_o,
   output level_e state_level_b_o,
   output logic shutdown_out_o,
   output logic [6:0] current_limit_ma_o,
   output logic polarity_reverse_o
);

   // Request port state
   logic select_n_q;
   logic power_on_hold;
   logic alert_hold;
   logic [1:0] req_latched;
   line_state_e state;
   line_state_e next_state;
   line_state_e req_state;

   // Registered sense and software control
   logic off_hook_q;
   logic ground_key_q;
   logic [1:0] ctrl;

   // Bus slave state
   logic aw_pend;
   logic w_pend;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [DATA_W-1:0] w_data_q;
   logic [3:0] w_strb_q;

   // Select edge and request decode
   wire select_active = ~select_n_i;
   wire select_rise = ~select_n_q & select_n_i;
   wire force_shutdown = ctrl[CTRL_FORCE_SHUTDOWN_BIT];

   // Select rising edge finds the request held from the last low cycle
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         select_n_q <= 1'b1;
      end else begin
         select_n_q <= select_n_i;
      end
   end

   // Requests only follow the pins while selected; otherwise they are ignored
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         power_on_hold <= 1'b0;
         alert_hold <= 1'b0;
      end else if (select_active) begin
         power_on_hold <= power_on_request_i;
         alert_hold <= alert_enable_i;
      end
   end

   // Decode of the request pair into a feed state
   always_comb begin
      case ({alert_hold, power_on_hold})
         2'b00: req_state = IDLE_FEED_STATE;
         2'b01: req_state = TALK_STATE;
         2'b10: req_state = LINE_SHUTDOWN_STATE;
         2'b11: req_state = RINGING_STATE;
         default: req_state = IDLE_FEED_STATE;
      endcase
   end

   // State moves only at the select rising edge; software can force shutdown
   always_comb begin
      next_state = state;
      if (select_rise) begin
         next_state = req_state;
      end
      if (force_shutdown) begin
         next_state = LINE_SHUTDOWN_STATE;
      end
   end

   // Operating state; starts in shutdown until the controller has spoken
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state <= LINE_SHUTDOWN_STATE;
         req_latched <= 2'h0;
      end else begin
         state <= next_state;
         if (select_rise) begin
            req_latched <= {alert_hold, power_on_hold};
         end
      end
   end

   // State pair decode from the next state, so the pins move on the same edge as shutdown
   level_e next_level_a;
   level_e next_level_b;
   always_comb begin
      case (next_state)
         TALK_STATE: begin
            next_level_a = LEVEL_POS;
            next_level_b = LEVEL_ZERO;
         end
         RINGING_STATE: begin
            next_level_a = LEVEL_NEG;
            next_level_b = LEVEL_ZERO;
         end
         default: begin
            // Stand-by and shutdown share the idle pair
            next_level_a = LEVEL_POS;
            next_level_b = LEVEL_POS;
         end
      endcase
   end

   // First and second state control pins
   tri_level_drive #(
      .RESET_LEVEL(LEVEL_POS)
   ) u_level_a (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .level_i(next_level_a),
      .level_o(state_level_a_o)
   );

   tri_level_drive #(
      .RESET_LEVEL(LEVEL_POS)
   ) u_level_b (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .level_i(next_level_b),
      .level_o(state_level_b_o)
   );

   // Feed limit per state; shutdown and ringing supply no regulated feed
   wire [6:0] talk_limit = ctrl[CTRL_LIMIT_LOW_BIT] ? LIMIT_TALK_LOW_MA : LIMIT_TALK_HIGH_MA;
   wire [6:0] next_limit = (next_state == IDLE_FEED_STATE) ? LIMIT_IDLE_MA :
                           (next_state == TALK_STATE) ? talk_limit : LIMIT_NONE_MA;
   wire next_shutdown = (next_state == LINE_SHUTDOWN_STATE);

   // Line driver controls, all registered
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         shutdown_out_o <= 1'b1;
         current_limit_ma_o <= LIMIT_NONE_MA;
         polarity_reverse_o <= 1'b0;
      end else begin
         shutdown_out_o <= next_shutdown;
         current_limit_ma_o <= next_limit;
         polarity_reverse_o <= 1'b0; // Direct polarity in every state
      end
   end

   // Sense indications pass a register stage before any output
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         off_hook_q <= 1'b0;
         ground_key_q <= 1'b0;
      end else begin
         off_hook_q <= off_hook_sense_i;
         ground_key_q <= ground_key_sense_i;
      end
   end

   // In shutdown no loop current flows, so the line reads on hook
   wire line_sensing = (state != LINE_SHUTDOWN_STATE);
   wire next_hook_level = ~(off_hook_q & line_sensing);
   wire next_ground_key_level = ~(ground_key_q & line_sensing);

   // Status pins: levels and enables; released while select is high
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         hook_state_out_o <= 1'b1;
         ground_key_out_o <= 1'b1;
         hook_state_out_oe_o <= 1'b0;
         ground_key_out_oe_o <= 1'b0;
      end else begin
         hook_state_out_o <= next_hook_level;
         ground_key_out_o <= next_ground_key_level; // Low when ground key seen
         hook_state_out_oe_o <= select_active;
         ground_key_out_oe_o <= select_active;
      end
   end

   // Write channel handshakes: address and data may come in either order
   wire aw_fire = axi_i.awvalid & axi_o.awready;
   wire w_fire = axi_i.wvalid & axi_o.wready;
   wire wr_do = aw_pend & w_pend & ~axi_o.bvalid;
   wire next_aw_pend = (aw_pend | aw_fire) & ~wr_do;
   wire next_w_pend = (w_pend | w_fire) & ~wr_do;
   wire next_bvalid = wr_do | (axi_o.bvalid & ~axi_i.bready);
   wire wr_hit_ctrl = (aw_addr_q == CTRL_OFFSET);
   wire wr_hit = wr_hit_ctrl | (aw_addr_q == STATUS_OFFSET);

   // Read channel: one read at a time, answered one cycle after acceptance
   wire ar_fire = axi_i.arvalid & axi_o.arready;
   wire next_rvalid = ar_fire | (axi_o.rvalid & ~axi_i.rready);
   wire rd_hit_ctrl = (axi_i.araddr == CTRL_OFFSET);
   wire rd_hit_status = (axi_i.araddr == STATUS_OFFSET);

   // Status word assembly; unused bits read zero
   logic [DATA_W-1:0] status_word;
   always_comb begin
      status_word = '0;
      status_word[STATUS_STATE_LSB +: 4] = state;
      status_word[STATUS_OFF_HOOK_BIT] = off_hook_q;
      status_word[STATUS_GROUND_KEY_BIT] = ground_key_q;
      status_word[STATUS_SELECTED_BIT] = select_active;
      status_word[STATUS_REQ_LSB +: 2] = req_latched;
   end

   wire [DATA_W-1:0] ctrl_word = {{(DATA_W-2){1'b0}}, ctrl};
   wire [DATA_W-1:0] next_rdata = rd_hit_ctrl ? ctrl_word : (rd_hit_status ? status_word : '0);

   // Write address and data capture
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         aw_pend <= 1'b0;
         w_pend <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= 4'h0;
      end else begin
         aw_pend <= next_aw_pend;
         w_pend <= next_w_pend;
         if (aw_fire) begin
            aw_addr_q <= axi_i.awaddr;
         end
         if (w_fire) begin
            w_data_q <= axi_i.wdata;
            w_strb_q <= axi_i.wstrb;
         end
      end
   end

   // Control register; status is read-only, writes to it are dropped silently
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         ctrl <= CTRL_RESET;
      end else if (wr_do && wr_hit_ctrl && w_strb_q[0]) begin
         ctrl <= w_data_q[1:0];
      end
   end

   // Bus answers, all registered; ready drops while a transfer is open
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         axi_o <= '0;
      end else begin
         axi_o.awready <= ~next_aw_pend & ~next_bvalid;
         axi_o.wready <= ~next_w_pend & ~next_bvalid;
         axi_o.bvalid <= next_bvalid;
         if (wr_do) begin
            axi_o.bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         axi_o.arready <= ~next_rvalid;
         axi_o.rvalid <= next_rvalid;
         if (ar_fire) begin
            axi_o.rdata <= next_rdata;
            axi_o.rresp <= (rd_hit_ctrl | rd_hit_status) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

endmodule

// ===== design/tri_level_drive.sv
// Purpose: Registered driver for one three-level state control pin.
// Assumes: Level code comes from a decoder that yields only legal codes.
// Notes: The reset level is a parameter so each pin starts at its idle level.
`timescale 1ns/1ps
module tri_level_drive
   import line_ctrl_pkg::*;
#(
   parameter level_e RESET_LEVEL = LEVEL_POS
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Wanted level
   input wire level_e level_i,
   // Pin code toward the line driver
   output level_e level_o
);

   // A flop per pin keeps decode glitches off the high voltage part
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         level_o <= RESET_LEVEL;
      end else begin
         level_o <= level_i;
      end
   end

endmodule

// ===== tb/line_ctrl_asserts.sv
// Purpose: Port checks for the line state control block.
// Assumes: The force-shutdown control bit stays clear during the run.
// Notes: Bound to the top module at the foot of this file.
`timescale 1ns/1ps
module line_ctrl_asserts
   import line_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Request port and sense
   input wire logic select_n_i,
   input wire logic power_on_request_i,
   input wire logic alert_enable_i,
   input wire logic off_hook_sense_i,
   input wire logic ground_key_sense_i,
   // Outputs under check
   input wire logic hook_state_out_o,
   input wire logic hook_state_out_oe_o,
   input wire logic ground_key_out_o,
   input wire logic ground_key_out_oe_o,
   input wire level_e state_level_a_o,
   input wire level_e state_level_b_o,
   input wire logic shutdown_out_o,
   input wire logic [6:0] current_limit_ma_o,
   input wire logic polarity_reverse_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // Status pins are released one edge after select goes high
   property p_oe;
      hook_state_out_oe_o == !$past(select_n_i) && ground_key_out_oe_o == hook_state_out_oe_o;
   endproperty
   a_oe: assert property (p_oe) else $error("status enable wrong");
   property p_legal;
      (state_level_b_o == LEVEL_POS && state_level_a_o == LEVEL_POS) ||
      (state_level_b_o == LEVEL_ZERO && state_level_a_o inside {LEVEL_POS, LEVEL_NEG});
   endproperty
   a_legal: assert property (p_legal) else $error("unused pair code");
   // Each request pair, latched at the select rising edge
   property p_sby;
      $rose(select_n_i) && !$past(power_on_request_i) && !$past(alert_enable_i) |=> state_level_b_o == LEVEL_POS
         && state_level_a_o == LEVEL_POS && current_limit_ma_o == LIMIT_IDLE_MA && !polarity_reverse_o;
   endproperty
   a_sby: assert property (p_sby) else $error("stand-by wrong");
   property p_talk;
      $rose(select_n_i) && $past(power_on_request_i) && !$past(alert_enable_i) |=>
         state_level_b_o == LEVEL_ZERO && state_level_a_o == LEVEL_POS && !shutdown_out_o;
   endproperty
   a_talk: assert property (p_talk) else $error("conversation wrong");
   property p_ring;
      $rose(select_n_i) && $past(power_on_request_i) && $past(alert_enable_i) |=>
         state_level_b_o == LEVEL_ZERO && state_level_a_o == LEVEL_NEG && !shutdown_out_o;
   endproperty
   a_ring: assert property (p_ring) else $error("ringing wrong");
   property p_pd;
      $rose(select_n_i) && !$past(power_on_request_i) && $past(alert_enable_i) |=> shutdown_out_o;
   endproperty
   a_pd: assert property (p_pd) else $error("power-down wrong");
   // Three edges of select high means no latch is pending
   property p_hold;
      select_n_i && $past(select_n_i) && $past(select_n_i, 2) |->
         $stable(state_level_a_o) && $stable(state_level_b_o) && $stable(shutdown_out_o);
   endproperty
   a_hold: assert property (p_hold) else $error("state moved while deselected");
   property p_sense;
      !shutdown_out_o && !$past(shutdown_out_o) && !$past(shutdown_out_o, 2) |->
         hook_state_out_o == !$past(off_hook_sense_i, 2) && ground_key_out_o == !$past(ground_key_sense_i, 2);
   endproperty
   a_sense: assert property (p_sense) else $error("status level wrong");
   property p_pdst;
      shutdown_out_o && $past(shutdown_out_o) |-> hook_state_out_o && ground_key_out_o;
   endproperty
   a_pdst: assert property (p_pdst) else $error("status active in power-down");
   // Reset itself must be watched, so this one is never disabled
   property p_rst;
      disable iff (1'b0) !resetn_i |=> shutdown_out_o && state_level_a_o == LEVEL_POS && state_level_b_o == LEVEL_POS;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule

bind line_interface_state_control line_ctrl_asserts u_chk (.*);

// ===== tb/line_ctrl_host.sv
// Purpose: Card controller model driving the select-gated request port.
// Assumes: One request cycle per go pulse; low_i is at least one.
// Notes: Requests flip after release to prove they are ignored.
`timescale 1ns/1ps
module line_ctrl_host (
   // Clock and command from the bench
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic [1:0] req_i,
   input wire logic [2:0] low_i,
   // Request port
   output logic select_n_o,
   output logic power_on_o,
   output logic alert_o,
   output logic busy_o
);
   logic [2:0] cnt;
   initial begin
      select_n_o = 1'b1;
      {alert_o, power_on_o} = 2'h0;
      busy_o = 1'b0;
      cnt = 3'h0;
   end
   // Select low for low_i cycles, requests held across the rising edge
   always @(posedge clk_i) begin
      if (go_i && !busy_o) begin
         busy_o <= 1'b1;
         select_n_o <= 1'b0;
         {alert_o, power_on_o} <= req_i; // Request pair as ordered by the bench
         cnt <= low_i;
      end else if (busy_o && !select_n_o) begin
         if (cnt <= 3'h1) select_n_o <= 1'b1; // Stable through latch edge
         cnt <= cnt - 3'h1;
      end else if (busy_o) begin
         busy_o <= 1'b0;
         {alert_o, power_on_o} <= ~{alert_o, power_on_o}; // Junk while deselected
      end
   end
endmodule

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the line state control block.
// Assumes: Controller model owns the request port; bench owns bus and sense.
// Notes: Force shutdown is never set, so the checker stays valid.
`timescale 1ns/1ps
module tb_top
   import line_ctrl_pkg::*;
;
   logic clk_i, resetn_i, go, busy, sel_n, pwr, alrt, hook_s, gk_s, exp_hook, hook, hook_oe, gk, gk_oe, sd, pol;
   logic [1:0] req, resp;
   logic [2:0] low;
   logic [6:0] lim;
   logic [31:0] rd;
   level_e lva, lvb;
   axi_req_s axi;
   axi_resp_s axi_o;
   int mismatches = 0;
   int compares = 0;
   int cyc = 0;
   // Expectations per code {alert, power_on}
   localparam logic [3:0] PAIR [4] = '{{LEVEL_POS, LEVEL_POS}, {LEVEL_ZERO, LEVEL_POS}, 4'h0, {LEVEL_ZERO, LEVEL_NEG}};
   localparam logic [6:0] LIM [4] = '{LIMIT_IDLE_MA, LIMIT_TALK_HIGH_MA, LIMIT_NONE_MA, LIMIT_NONE_MA};
   localparam logic [1:0] SEQ [6] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h2, 2'h1};
   line_interface_state_control DUT (.clk_i(clk_i), .resetn_i(resetn_i), .axi_i(axi), .axi_o(axi_o),
      .select_n_i(sel_n), .power_on_request_i(pwr), .alert_enable_i(alrt), .off_hook_sense_i(hook_s),
      .ground_key_sense_i(gk_s), .hook_state_out_o(hook), .hook_state_out_oe_o(hook_oe), .ground_key_out_o(gk),
      .ground_key_out_oe_o(gk_oe), .state_level_a_o(lva), .state_level_b_o(lvb), .shutdown_out_o(sd),
      .current_limit_ma_o(lim), .polarity_reverse_o(pol));
   line_ctrl_host host (.clk_i(clk_i), .go_i(go), .req_i(req), .low_i(low), .select_n_o(sel_n),
      .power_on_o(pwr), .alert_o(alrt), .busy_o(busy));
   task automatic report_and_stop;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Bus master: holds each channel until its ready, waits for the answer
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      axi.awvalid <= 1'b1;
      axi.awaddr <= a;
      axi.wvalid <= 1'b1;
      axi.wdata <= d;
      axi.wstrb <= 4'hF;
      axi.bready <= 1'b1;
      do begin
         @(posedge clk_i);
         if (axi_o.awready) axi.awvalid <= 1'b0;
         if (axi_o.wready) axi.wvalid <= 1'b0;
      end while (!axi_o.bvalid);
      r = axi_o.bresp;
      axi.bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      axi.arvalid <= 1'b1;
      axi.araddr <= a;
      axi.rready <= 1'b1;
      do begin
         @(posedge clk_i);
         if (axi_o.arready) axi.arvalid <= 1'b0;
      end while (!axi_o.rvalid);
      d = axi_o.rdata;
      r = axi_o.rresp;
      axi.rready <= 1'b0;
   endtask
   // One select cycle; long ones also check the status pins mid-cycle
   task automatic line_req(input logic [1:0] q, input logic [2:0] lo);
      @(posedge clk_i);
      go <= 1'b1;
      req <= q;
      low <= lo;
      @(posedge clk_i);
      go <= 1'b0;
      while (sel_n) @(posedge clk_i);
      if (lo > 3'h2) begin
         repeat (2) @(posedge clk_i);
         chk("status oe", 2'h3, {hook_oe, gk_oe});
         chk("status pins", {2{exp_hook}}, {hook, gk});
      end
      while (busy) @(posedge clk_i);
      repeat (2) @(posedge clk_i);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // Hang guard, far above the roughly 120 cycles the tests need
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         mismatches++;
         report_and_stop;
      end
   end
   initial begin
      resetn_i = 1'b0;
      axi = '0;
      go = 1'b0;
      req = 2'h0;
      low = 3'h1;
      hook_s = 1'b0;
      gk_s = 1'b0;
      exp_hook = 1'b1;
      repeat (4) @(posedge clk_i);
      resetn_i <= 1'b1;
      chk("shutdown", 1, sd);
      chk("pair", {LEVEL_POS, LEVEL_POS}, {lvb, lva});
      axi_rd(CTRL_OFFSET, rd, resp);
      chk("ctrl reset", {30'h0, CTRL_RESET}, rd);
      axi_rd(8'h10, rd, resp);
      chk("unmapped resp", RESP_SLVERR, resp);
      chk("unmapped data", 0, rd);
      // Every request code, short and long select, back to back
      for (int i = 0; i < 6; i++) begin
         line_req(SEQ[i], i[0] ? 3'h3 : 3'h1);
         if (SEQ[i] != 2'h2) chk("pair", PAIR[SEQ[i]], {lvb, lva});
         chk("shutdown", SEQ[i] == 2'h2, sd);
         chk("limit", LIM[SEQ[i]], lim);
      end
      hook_s <= 1'b1;
      gk_s <= 1'b1;
      exp_hook = 1'b0;
      repeat (3) @(posedge clk_i);
      chk("oe idle", 0, hook_oe);
      line_req(2'h1, 3'h4);
      axi_wr(CTRL_OFFSET, 32'h1, resp);
      chk("ctrl resp", RESP_OKAY, resp);
      repeat (2) @(posedge clk_i);
      chk("limit low", LIMIT_TALK_LOW_MA, lim);
      axi_wr(STATUS_OFFSET, 32'hFFFF_FFFF, resp);
      chk("status wr resp", RESP_OKAY, resp);
      axi_rd(STATUS_OFFSET, rd, resp);
      chk("status", 32'h0000_0132, rd);
      line_req(2'h0, 3'h1);
      line_req(2'h0, 3'h4);
      line_req(2'h2, 3'h1);
      exp_hook = 1'b1;
      line_req(2'h2, 3'h4);
      report_and_stop;
   end
endmodule
